/* File: src/bsd_consts.svh */
// Constants of the boot strap decoder: offsets, field positions, defaults, control bits
// Function
// RQ1: Minimal-strapping flag at 1 makes every boot field take its default value.
// RQ2: With that flag set, all other main boot straps are ignored.
// RQ3: Eight primary media settings pass through, meaning set by the primary device.
// RQ4: Three backup media settings pass through, meaning set by the backup device.
// RQ5: Board drives a backup setting strap 1 for switch on, 0 for off.
// RQ6: Reference code 0-5 gives 19.2/20/24/25/26/27 MHz, 6 reserved, 7 skips PLL.
// RQ7: Board straps the reference code for 25 MHz by default.
// RQ8: Fail-safe code 00 none, 01 I2C port 0, 10 SPI port 0, 11 NOR port 0.
// RQ9: External emulator attached disables the on-board emulation circuitry.
// RQ10: Lowest four straps pick the primary device; reserved codes act as no boot.
// RQ11: Straps six to four pick the backup device, tried only after primary fails.
// RQ12: Straps captured once at reset release and held until the next reset.
// RQ13: Six reserved upper microcontroller straps are ignored; board drives them 0.
`ifndef BSD_CONSTS_SVH
`define BSD_CONSTS_SVH

// ************************************************************
// Strap field positions
// ************************************************************
`define BSD_PDEV_LSB       0
`define BSD_BDEV_LSB       4
`define BSD_MIN_BIT        7
`define BSD_PCFG_LSB       8
`define BSD_BCFG_LSB       16
`define BSD_REF_LSB        0
`define BSD_FS_LSB         3

// ************************************************************
// Device codes and defaults
// ************************************************************
`define BSD_PDEV_NONE      4'h0
`define BSD_PDEV_RSV_B     4'hB
`define BSD_PDEV_RSV_E     4'hE
`define BSD_PDEV_RSV_F     4'hF
`define BSD_BDEV_NONE      3'h0
`define BSD_DEF_PDEV       4'h1
`define BSD_DEF_BDEV       3'h0
`define BSD_DEF_PCFG       8'h00
`define BSD_DEF_BCFG       3'h0
`define BSD_DEF_REF        3'h3
`define BSD_DEF_FS         2'h0
`define BSD_REF_RSV        3'h6
`define BSD_REF_SKIP       3'h7

// ************************************************************
// Register offsets (byte addresses) and control bits
// ************************************************************
`define BSD_OFF_RAW        8'h00
`define BSD_OFF_DEC        8'h04
`define BSD_OFF_MCU        8'h08
`define BSD_OFF_CTRL       8'h0C
`define BSD_OFF_STAT       8'h10
`define BSD_CTRL_EMU_OFF   0
`define BSD_CTRL_PFAIL     1
`define BSD_CTRL_RST       2'h0

`endif

/* File: src/bsd_pkg.sv */
// Types shared by the boot strap decoder files
package bsd_pkg;

   // ************************************************************
   // Decoded boot configuration
   // ************************************************************
   typedef struct packed {
      logic        min;
      logic [3:0]  prim_dev;
      logic [2:0]  bkup_dev;
      logic [7:0]  prim_cfg;
      logic [2:0]  bkup_cfg;
      logic [2:0]  ref_code;
      logic [14:0] ref_khz;
      logic        pll_skip;
      logic [1:0]  fs_code;
      logic [2:0]  fs_sel;
   } bsd_cfg_t;

   // ************************************************************
   // State machines
   // ************************************************************
   typedef enum logic {BSD_CAP_WAIT, BSD_CAP_HOLD} bsd_cap_st_t;
   typedef enum logic {BSD_BUS_IDLE, BSD_BUS_ACK} bsd_bus_st_t;

endpackage

/* File: src/bsd_decode.sv */
// Combinational decode of the raw strap levels into a boot configuration
`timescale 1ns/1ps
`include "bsd_consts.svh"
module bsd_decode (
   // Raw straps
   input  wire logic [18:0]       boot_strap_i,
   input  wire logic [10:0]       mcu_strap_i,
   // Decoded result
   output bsd_pkg::bsd_cfg_t      cfg_o
);
   import bsd_pkg::*;

   // ************************************************************
   // Decode functions
   // ************************************************************
   function automatic logic [3:0] pdev_f(input logic [3:0] code);
      logic rsv;
      rsv = (code == `BSD_PDEV_RSV_B) || (code == `BSD_PDEV_RSV_E) ||
            (code == `BSD_PDEV_RSV_F);
      pdev_f = rsv ? `BSD_PDEV_NONE : code; // RQ10
   endfunction

   function automatic logic [14:0] khz_f(input logic [2:0] code);
      case (code) // RQ6
         3'h0:    khz_f = 15'h4B00;
         3'h1:    khz_f = 15'h4E20;
         3'h2:    khz_f = 15'h5DC0;
         3'h3:    khz_f = 15'h61A8;
         3'h4:    khz_f = 15'h6590;
         3'h5:    khz_f = 15'h6978;
         default: khz_f = 15'h0000;
      endcase
   endfunction

   // ************************************************************
   // Field selection
   // ************************************************************
   logic       min;
   logic [2:0] ref_code;
   logic [1:0] fs_code;

   assign min      = boot_strap_i[`BSD_MIN_BIT];
   assign ref_code = mcu_strap_i[`BSD_REF_LSB +: 3];
   // Upper six microcontroller straps are never looked at
   assign fs_code  = mcu_strap_i[`BSD_FS_LSB +: 2]; // RQ13

   // Defaults replace every main field while the flag is set
   assign cfg_o.min      = min;
   assign cfg_o.prim_dev = min ? `BSD_DEF_PDEV :
                           pdev_f(boot_strap_i[`BSD_PDEV_LSB +: 4]); // RQ1 RQ10
   assign cfg_o.bkup_dev = min ? `BSD_DEF_BDEV :
                           boot_strap_i[`BSD_BDEV_LSB +: 3]; // RQ2 RQ11
   assign cfg_o.prim_cfg = min ? `BSD_DEF_PCFG :
                           boot_strap_i[`BSD_PCFG_LSB +: 8]; // RQ3
   assign cfg_o.bkup_cfg = min ? `BSD_DEF_BCFG :
                           boot_strap_i[`BSD_BCFG_LSB +: 3]; // RQ4 RQ5
   assign cfg_o.ref_code = ref_code;
   assign cfg_o.ref_khz  = khz_f(ref_code); // RQ6
   assign cfg_o.pll_skip = (ref_code == `BSD_REF_SKIP); // RQ6
   assign cfg_o.fs_code  = fs_code;

   // One-hot fail-safe port select: I2C, SPI, NOR
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_fs
         assign cfg_o.fs_sel[g] = (fs_code == 2'(g + 1)); // RQ8
      end
   endgenerate

endmodule

/* File: src/bsd_top.sv */
// Boot strap decoder top: capture, hold, emulation select and register slave
`timescale 1ns/1ps
`include "bsd_consts.svh"
module bsd_top (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   // Strap pins
   input  wire logic [18:0]        boot_strap_i,
   input  wire logic [10:0]        mcu_strap_i,
   input  wire logic               ext_emu_i,
   // Decoded boot settings
   output bsd_pkg::bsd_cfg_t       cfg_o,
   output logic                    captured_o,
   output logic                    use_backup_o,
   output logic                    onboard_emu_en_o,
   // Avalon-MM slave
   input  wire logic [7:0]         avs_address_i,
   input  wire logic               avs_read_i,
   input  wire logic               avs_write_i,
   input  wire logic [31:0]        avs_writedata_i,
   input  wire logic [3:0]         avs_byteenable_i,
   output logic [31:0]             avs_readdata_o,
   output logic                    avs_waitrequest_o
);
   import bsd_pkg::*;

   // ************************************************************
   // Decode of live straps
   // ************************************************************
   bsd_cfg_t dec_cfg;

   bsd_decode u_decode (
      .boot_strap_i (boot_strap_i),
      .mcu_strap_i  (mcu_strap_i),
      .cfg_o        (dec_cfg)
   );

   // Reset value of the held configuration
   function automatic bsd_cfg_t rst_cfg_f();
      bsd_cfg_t c;
      c          = '0;
      c.prim_dev = `BSD_DEF_PDEV;
      c.ref_code = `BSD_DEF_REF;
      return c;
   endfunction

   // ************************************************************
   // Capture state
   // ************************************************************
   bsd_cap_st_t cap_st_ff;
   bsd_cap_st_t nxt_cap_st;
   bsd_cfg_t    cfg_ff;
   bsd_cfg_t    nxt_cfg;
   logic [18:0] raw_ff;
   logic [18:0] nxt_raw;
   logic [10:0] mcu_ff;
   logic [10:0] nxt_mcu;
   logic        captured_ff;
   logic        nxt_captured;

   // Straps are sampled on the first edge after reset release, never later,
   // so a switch moved while running has no effect until the next reset
   always_comb begin
      nxt_cap_st = cap_st_ff;
      nxt_cfg    = cfg_ff;
      nxt_raw    = raw_ff;
      nxt_mcu    = mcu_ff;
      case (cap_st_ff)
         BSD_CAP_WAIT: begin
            nxt_cfg    = dec_cfg; // RQ12
            nxt_raw    = boot_strap_i;
            nxt_mcu    = mcu_strap_i;
            nxt_cap_st = BSD_CAP_HOLD;
         end
         BSD_CAP_HOLD: begin
            nxt_cap_st = BSD_CAP_HOLD; // RQ12
         end
         default: begin
            nxt_cap_st = BSD_CAP_WAIT;
         end
      endcase
      nxt_captured = (nxt_cap_st == BSD_CAP_HOLD);
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cap_st_ff <= BSD_CAP_WAIT;
         cfg_ff    <= rst_cfg_f();
         raw_ff    <= 19'h00000;
         mcu_ff    <= 11'h000;
         captured_ff <= 1'b0;
      end else begin
         cap_st_ff <= nxt_cap_st;
         cfg_ff    <= nxt_cfg;
         raw_ff    <= nxt_raw;
         mcu_ff    <= nxt_mcu;
         captured_ff <= nxt_captured;
      end
   end

   // ************************************************************
   // Control, emulation and boot device selection
   // ************************************************************
   bsd_bus_st_t bus_st_ff;
   bsd_bus_st_t nxt_bus_st;
   logic        wr_go;
   logic [1:0]  ctrl_ff;
   logic [1:0]  nxt_ctrl;
   logic        emu_en_ff;
   logic        nxt_emu_en;
   logic        bkup_ff;
   logic        nxt_bkup;

   assign wr_go = avs_write_i && (bus_st_ff == BSD_BUS_ACK);

   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_go && (avs_address_i == `BSD_OFF_CTRL) && avs_byteenable_i[0]) begin
         nxt_ctrl = avs_writedata_i[1:0];
      end
      // Emulator presence is a live level, not a captured strap
      nxt_emu_en = !(ext_emu_i || ctrl_ff[`BSD_CTRL_EMU_OFF]); // RQ9
      // Backup is only entered once the primary was reported failed and a
      // backup device exists; it stays until the next reset
      nxt_bkup = bkup_ff;
      if ((cap_st_ff == BSD_CAP_HOLD) && ctrl_ff[`BSD_CTRL_PFAIL] &&
          (cfg_ff.bkup_dev != `BSD_BDEV_NONE)) begin
         nxt_bkup = 1'b1; // RQ11
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_ff   <= `BSD_CTRL_RST;
         emu_en_ff <= 1'b0;
         bkup_ff   <= 1'b0;
      end else begin
         ctrl_ff   <= nxt_ctrl;
         emu_en_ff <= nxt_emu_en;
         bkup_ff   <= nxt_bkup;
      end
   end

   // ************************************************************
   // Avalon-MM slave: one wait cycle, answer on the second edge
   // ************************************************************
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic        wait_ff;
   logic        nxt_wait;

   function automatic logic [31:0] rd_mux_f(input logic [7:0] adr);
      case (adr)
         `BSD_OFF_RAW:  rd_mux_f = {13'h0000, raw_ff};
         `BSD_OFF_DEC:  rd_mux_f = {13'h0000, cfg_ff.bkup_cfg, cfg_ff.prim_cfg,
                                    cfg_ff.min, cfg_ff.bkup_dev, cfg_ff.prim_dev};
         `BSD_OFF_MCU:  rd_mux_f = {cfg_ff.ref_khz, 7'h00, cfg_ff.fs_sel,
                                    cfg_ff.pll_skip, 1'b0, cfg_ff.fs_code,
                                    cfg_ff.ref_code}; // RQ13
         `BSD_OFF_CTRL: rd_mux_f = {30'h00000000, ctrl_ff};
         `BSD_OFF_STAT: rd_mux_f = {28'h0000000, ext_emu_i, emu_en_ff, bkup_ff,
                                    cap_st_ff == BSD_CAP_HOLD};
         default:       rd_mux_f = 32'h00000000;
      endcase
   endfunction

   always_comb begin
      nxt_bus_st = bus_st_ff;
      nxt_wait   = 1'b1;
      nxt_rdata  = rdata_ff;
      case (bus_st_ff)
         BSD_BUS_IDLE: begin
            if (avs_read_i || avs_write_i) begin
               nxt_bus_st = BSD_BUS_ACK;
               nxt_wait   = 1'b0;
               nxt_rdata  = rd_mux_f(avs_address_i);
            end
         end
         BSD_BUS_ACK: begin
            nxt_bus_st = BSD_BUS_IDLE;
         end
         default: begin
            nxt_bus_st = BSD_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bus_st_ff <= BSD_BUS_IDLE;
         wait_ff   <= 1'b1;
         rdata_ff  <= 32'h00000000;
      end else begin
         bus_st_ff <= nxt_bus_st;
         wait_ff   <= nxt_wait;
         rdata_ff  <= nxt_rdata;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign cfg_o             = cfg_ff;
   assign captured_o        = captured_ff;
   assign use_backup_o      = bkup_ff;
   assign onboard_emu_en_o  = emu_en_ff;
   assign avs_readdata_o    = rdata_ff;
   assign avs_waitrequest_o = wait_ff;

   // ************************************************************
   // Assertions
   // ************************************************************
   // Ends on the edge after capture, so $past sees the captured strap level
   sequence s_first_cap;
      !captured_o ##1 captured_o;
   endsequence

   sequence s_bus_req;
      (avs_read_i || avs_write_i) && avs_waitrequest_o && (bus_st_ff == BSD_BUS_IDLE);
   endsequence

   sequence s_bus_done;
      (avs_read_i || avs_write_i) && !avs_waitrequest_o;
   endsequence

   a_min_defaults: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ1
      s_first_cap ##0 $past(boot_strap_i[`BSD_MIN_BIT]) |->
         cfg_o.prim_dev == `BSD_DEF_PDEV && cfg_o.bkup_dev == `BSD_DEF_BDEV)
      else $error("min flag did not give default devices");

   a_min_ignores: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ2
      captured_o && cfg_o.min |-> cfg_o.prim_cfg == `BSD_DEF_PCFG &&
         cfg_o.bkup_cfg == `BSD_DEF_BCFG)
      else $error("straps used while min flag set");

   a_prim_cfg_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ3
      captured_o && !cfg_o.min |-> cfg_o.prim_cfg == raw_ff[15:8])
      else $error("primary media settings not passed through");

   a_bkup_cfg_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ4
      captured_o && !cfg_o.min |-> cfg_o.bkup_cfg == raw_ff[18:16])
      else $error("backup media settings not passed through");

   a_ref_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ6
      captured_o |-> (cfg_o.pll_skip == (mcu_ff[2:0] == 3'h7)) &&
         ((mcu_ff[2:0] == 3'h3) == (cfg_o.ref_khz == 15'h61A8)) &&
         (mcu_ff[2:0] != `BSD_REF_RSV || cfg_o.ref_khz == 15'h0000))
      else $error("reference clock decode wrong");

   a_fs_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ8
      captured_o |-> cfg_o.fs_sel == ((mcu_ff[4:3] == 2'h0) ? 3'h0 :
         3'(1 << (mcu_ff[4:3] - 2'h1))))
      else $error("fail-safe select wrong");

   a_emu_off: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ9
      ext_emu_i |=> !onboard_emu_en_o)
      else $error("on-board emulation left on with external emulator");

   a_rsv_no_boot: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ10
      captured_o && !cfg_o.min && (raw_ff[3:0] >= `BSD_PDEV_RSV_E ||
         raw_ff[3:0] == `BSD_PDEV_RSV_B) |->
         cfg_o.prim_dev == `BSD_PDEV_NONE)
      else $error("reserved primary code not treated as no boot");

   a_bkup_only_fail: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ11
      $rose(use_backup_o) |-> $past(ctrl_ff[`BSD_CTRL_PFAIL]) &&
         cfg_o.bkup_dev != `BSD_BDEV_NONE)
      else $error("backup used without primary failure");

   a_hold_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ12
      captured_o ##1 rst_n_i |-> $stable(cfg_o) && $stable(raw_ff))
      else $error("held configuration changed");

   a_mcu_rsv_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ13
      s_bus_done ##0 ($past(captured_o) && avs_read_i && (avs_address_i == `BSD_OFF_MCU)) |->
         avs_readdata_o[16:10] == 7'h00 && avs_readdata_o[4:0] == mcu_ff[4:0])
      else $error("reserved straps visible");

   a_bus_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_bus_req |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not one cycle after request");

   a_wait_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !avs_read_i && !avs_write_i |=> avs_waitrequest_o)
      else $error("bus answered without a request");

   a_ctrl_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_bus_done ##0 (avs_write_i && (avs_address_i == `BSD_OFF_CTRL) &&
         avs_byteenable_i[0]) |=> ctrl_ff == $past(avs_writedata_i[1:0]))
      else $error("control write did not land");

   a_dec_upper: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_bus_done ##0 (avs_read_i && (avs_address_i == `BSD_OFF_DEC)) |->
         avs_readdata_o[31:19] == 13'h0000)
      else $error("decoded word upper bits not zero");

   a_bkup_enter: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ11
      captured_o && ctrl_ff[`BSD_CTRL_PFAIL] && cfg_o.bkup_dev != `BSD_BDEV_NONE |=>
         use_backup_o)
      else $error("backup not taken after primary failure");

   a_emu_on: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ9
      !ext_emu_i && !ctrl_ff[`BSD_CTRL_EMU_OFF] |=> onboard_emu_en_o)
      else $error("on-board emulation off without cause");

endmodule

/* File: testbench/bsd_strap_board.sv */
// Board model: strap switches and reserved-bit wiring in front of the decoder
`timescale 1ns/1ps
module bsd_strap_board (
   // Clock
   input  wire logic        clk_i,
   // Switch settings
   input  wire logic [18:0] sw_main_i,
   input  wire logic [10:0] sw_mcu_i,
   input  wire logic        min_only_i,
   input  wire logic        rsv_junk_i,
   // Strap pins
   output logic [18:0]      boot_strap_o,
   output logic [10:0]      mcu_strap_o
);
   logic [18:0] float_ff = 19'h15A5A;

   // Ten of the undriven straps toggle every cycle, so a decoder that reads them cannot match by luck
   always @(posedge clk_i) begin
      float_ff <= ~float_ff ^ 19'h2A5A5;
   end

   always_comb begin
      boot_strap_o = sw_main_i;
      if (min_only_i) begin
         boot_strap_o    = float_ff;
         boot_strap_o[7] = 1'b1;
      end
      mcu_strap_o = {rsv_junk_i ? sw_mcu_i[10:5] : 6'h00, sw_mcu_i[4:0]};
   end
endmodule

/* File: testbench/boot_strap_decoder_tb.sv */
// Self-checking testbench of the boot strap decoder
`timescale 1ns/1ps
`include "bsd_consts.svh"
module boot_strap_decoder_tb;
   import bsd_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [18:0] sw_main = 19'h00000;
   logic [10:0] sw_mcu = 11'h003;
   logic        min_only = 1'b0;
   logic        rsv_junk = 1'b0;
   logic        ext_emu = 1'b0;
   logic [18:0] boot_strap;
   logic [10:0] mcu_strap;
   bsd_cfg_t    cfg;
   logic        captured, use_backup, emu_en, avs_waitrequest;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   int          seed = 32'h3333;
   int          err_count = 0;
   int          checks_done = 0;

   always #5 clk_i = ~clk_i;

   bsd_strap_board i_bsd_strap_board (.clk_i(clk_i), .sw_main_i(sw_main), .sw_mcu_i(sw_mcu),
      .min_only_i(min_only), .rsv_junk_i(rsv_junk), .boot_strap_o(boot_strap),
      .mcu_strap_o(mcu_strap));

   bsd_top i_bsd_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .boot_strap_i(boot_strap),
      .mcu_strap_i(mcu_strap), .ext_emu_i(ext_emu), .cfg_o(cfg), .captured_o(captured),
      .use_backup_o(use_backup), .onboard_emu_en_o(emu_en), .avs_address_i(avs_address),
      .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
      .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
      .avs_waitrequest_o(avs_waitrequest));

   // ************************************************************
   // Expectation and checking
   // ************************************************************
   function automatic bsd_cfg_t exp_cfg(input logic [18:0] b, input logic [10:0] m);
      bsd_cfg_t c;
      c = '0;
      c.min = b[7];
      c.prim_dev = `BSD_DEF_PDEV;
      if (!b[7]) begin
         c.prim_dev = (b[3:0] == 4'hB || b[3:0] > 4'hD) ? 4'h0 : b[3:0];
         c.bkup_dev = b[6:4];
         c.prim_cfg = b[15:8];
         c.bkup_cfg = b[18:16];
      end
      c.ref_code = m[2:0];
      case (m[2:0])
         3'h0: c.ref_khz = 15'h4B00;
         3'h1: c.ref_khz = 15'h4E20;
         3'h2: c.ref_khz = 15'h5DC0;
         3'h3: c.ref_khz = 15'h61A8;
         3'h4: c.ref_khz = 15'h6590;
         3'h5: c.ref_khz = 15'h6978;
         default: c.ref_khz = 15'h0000;
      endcase
      c.pll_skip = (m[2:0] == 3'h7);
      c.fs_code = m[4:3];
      c.fs_sel = (m[4:3] == 2'h0) ? 3'h0 : (3'h1 << (m[4:3] - 2'h1));
      return c;
   endfunction

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Avalon-MM master: hold the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] rd);
      @(posedge clk_i);
      avs_address <= a;
      avs_writedata <= wd;
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      // Only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge clk_i);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, 4'h0, d);
      chk(d, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] x;
      bus(1'b1, a, d, be, x);
   endtask

   task automatic conclude;
      $display("Checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Limit is far above the roughly 620 cycles the sequence needs
   initial begin
      #300000;
      err_count++;
      conclude();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      logic [18:0] bs;
      logic [10:0] mc;
      logic        mn, emu;
      bsd_cfg_t    ex, rc;
      rc = '0;
      rc.prim_dev = `BSD_DEF_PDEV;
      rc.ref_code = `BSD_DEF_REF;
      // Every primary code is set once (4, 9 and E only under the minimal flag), every reference and fail-safe code at least once, across the loop
      for (int i = 0; i < 16; i++) begin
         bs = 19'($random(seed));
         mc = 11'($random(seed));
         emu = 1'($random(seed));
         mn = (i % 5 == 4);
         bs[3:0] = i[3:0];
         bs[7] = mn;
         mc[4:0] = {i[1:0], i[2:0]};
         if (i == 0) mc[4:0] = 5'h03;
         ex = exp_cfg(bs, mc);
         @(posedge clk_i);
         rst_n_i <= 1'b0;
         sw_main <= bs;
         sw_mcu <= mc;
         min_only <= mn;
         rsv_junk <= i[0];
         ext_emu <= emu;
         repeat (3) @(posedge clk_i);
         #1;
         chk({cfg, captured, use_backup, emu_en, avs_waitrequest}, {rc, 4'h1});
         @(posedge clk_i);
         rst_n_i <= 1'b1;
         @(posedge clk_i);
         #1;
         chk({cfg, captured}, {ex, 1'b1});
         chk(emu_en, !emu);
         // Straps moving after capture must not disturb the held result
         @(posedge clk_i);
         sw_main <= ~bs;
         sw_mcu <= ~mc;
         min_only <= 1'b0;
         ext_emu <= !emu;
         @(posedge clk_i);
         #1;
         chk(emu_en, emu);
         @(posedge clk_i);
         #1;
         chk(cfg, ex);
         if (!mn) rchk(`BSD_OFF_RAW, {13'h0, bs});
         wr(`BSD_OFF_DEC, 32'hFFFFFFFF, 4'hF);
         rchk(`BSD_OFF_DEC, {13'h0, ex.bkup_cfg, ex.prim_cfg, ex.min, ex.bkup_dev,
                             ex.prim_dev});
         rchk(`BSD_OFF_MCU, {ex.ref_khz, 7'h00, ex.fs_sel, ex.pll_skip, 1'b0, ex.fs_code,
                             ex.ref_code});
         rchk(8'h14, 32'h0);
         rchk(`BSD_OFF_STAT, {28'h0, !emu, emu, 2'h1});
         wr(`BSD_OFF_CTRL, 32'h2, 4'h0);
         @(posedge clk_i);
         #1;
         chk(use_backup, 1'b0);
         wr(`BSD_OFF_CTRL, 32'h2, 4'h1);
         @(posedge clk_i);
         #1;
         chk(use_backup, ex.bkup_dev != 3'h0);
         wr(`BSD_OFF_CTRL, 32'h1, 4'h1);
         @(posedge clk_i);
         #1;
         chk({use_backup, emu_en}, {ex.bkup_dev != 3'h0, 1'b0});
      end
      conclude();
   end
endmodule
